// file: inc/tccp_defs.svh
/*
  Register offsets, field positions, reset values for the timer/capture/compare block.
  Assumes inclusion by bare name from the channel and timer modules.
*/
`ifndef TCCP_DEFS_SVH
`define TCCP_DEFS_SVH

`define TCCP_OFF_CTRL     8'h00
`define TCCP_OFF_TOP      8'h04
`define TCCP_OFF_CNT      8'h08
`define TCCP_OFF_STATUS   8'h0c
`define TCCP_OFF_CLEAR    8'h10
`define TCCP_OFF_DTIME    8'h14
`define TCCP_OFF_CHCFG0   8'h20
`define TCCP_OFF_CHVAL0   8'h40
`define TCCP_CH_STRIDE    8'h04

`define TCCP_CTRL_RUN     0
`define TCCP_CTRL_EXTCLK  1
`define TCCP_CTRL_DTEN    2
`define TCCP_CFG_MODE_LO  0
`define TCCP_CFG_EDGE_LO  2
`define TCCP_CFG_INV      4
`define TCCP_STAT_OVF     4

`define TCCP_RST_TOP      16'hffff
`define TCCP_RST_DTIME    8'h00

`endif

// file: inc/tccp_pkg.sv
/*
  Types for the timer/capture/compare block.
  Assumes tccp_defs.svh is on the include path.
*/
package tccp_pkg;
  // Channel operating mode; all four codes are legal, code 3 selects PWM
  typedef enum logic [1:0] {
    TCCP_MODE_OFF,
    TCCP_MODE_CAPTURE,
    TCCP_MODE_COMPARE,
    TCCP_MODE_PWM
  } tccp_mode_t;

  // Capture edge select
  typedef enum logic [1:0] {
    TCCP_EDGE_RISE,
    TCCP_EDGE_FALL,
    TCCP_EDGE_BOTH,
    TCCP_EDGE_NONE
  } tccp_edge_t;
endpackage

// file: src/tccp_channel.sv
/*
  One capture/compare/PWM channel against the shared counter.
  Assumes the counter and wrap strobe come from the parent, same clock.
*/
`include "tccp_defs.svh"
module tccp_channel
  import tccp_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic          clk,        // Core clock
  input  wire logic          rst,        // Sync reset
  input  wire logic [1:0]    mode,       // Channel mode
  input  wire logic [1:0]    edge_sel,   // Capture edge select
  input  wire logic          inv,        // Output polarity invert
  input  wire logic [CW-1:0] cnt,        // Shared counter value
  input  wire logic          tick,       // Counter advances this cycle
  input  wire logic          wrap,       // Counter wraps this cycle
  input  wire logic          cap_in,     // Capture input level
  input  wire logic          val_we,     // Software writes threshold
  input  wire logic [CW-1:0] val_wd,     // Threshold write data
  output logic [CW-1:0]      val,        // Threshold or captured value
  output logic               hit,        // Event pulse
  output logic               out         // Channel output level
);
  logic          cap_prev_q;
  logic [CW-1:0] buf_q;
  logic          out_q;
  logic          match;
  logic          cap_ev;

  assign match = tick && (cnt == buf_q);
  // Edge detect on the sampled capture input
  always_comb begin
    unique case (tccp_edge_t'(edge_sel))
      TCCP_EDGE_RISE: cap_ev = cap_in && !cap_prev_q;
      TCCP_EDGE_FALL: cap_ev = !cap_in && cap_prev_q;
      TCCP_EDGE_BOTH: cap_ev = cap_in ^ cap_prev_q;
      TCCP_EDGE_NONE: cap_ev = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) cap_prev_q <= 1'b0;
    else cap_prev_q <= cap_in;
  end

  // Buffer: captured count in capture mode, threshold otherwise
  always_ff @(posedge clk) begin
    if (rst) buf_q <= '0;
    else if (mode == TCCP_MODE_CAPTURE && cap_ev) buf_q <= cnt;
    else if (val_we) buf_q <= val_wd;
  end

  // Output: compare toggles on match, PWM sets at wrap, clears at match
  always_ff @(posedge clk) begin
    if (rst) out_q <= 1'b0;
    else begin
      unique case (tccp_mode_t'(mode))
        TCCP_MODE_COMPARE: if (match) out_q <= !out_q;
        TCCP_MODE_PWM: begin
          if (match) out_q <= 1'b0;
          else if (wrap) out_q <= 1'b1;
        end
        default: out_q <= 1'b0;
      endcase
    end
  end

  assign val = buf_q;
  assign out = out_q ^ inv;
  // Event pulse: capture or threshold match
  assign hit = (mode == TCCP_MODE_CAPTURE) ? cap_ev
             : ((mode == TCCP_MODE_COMPARE || mode == TCCP_MODE_PWM) && match);
endmodule

// file: src/tccp_deadtime.sv
/*
  Dead-time inserter: splits one PWM level into a complementary pair
  with a programmable gap. Assumes same clock as the parent.
*/
module tccp_deadtime #(
  parameter int DW = 8
) (
  input  wire logic          clk,     // Core clock
  input  wire logic          rst,     // Sync reset
  input  wire logic          en,      // Insertion enabled
  input  wire logic [DW-1:0] gap,     // Dead time in clocks
  input  wire logic          pwm,     // Raw PWM level
  output logic               hi,      // High-side drive
  output logic               lo       // Low-side drive
);
  logic          last_q;
  logic [DW-1:0] cnt_q;

  // Restart the gap at every edge of the raw level
  always_ff @(posedge clk) begin
    if (rst) begin
      last_q <= 1'b0;
      cnt_q  <= '0;
    end else begin
      last_q <= pwm;
      if (pwm != last_q) cnt_q <= gap;
      else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
    end
  end

  // Both sides low while the gap runs, so they never overlap
  assign hi = en ? (pwm && pwm == last_q && cnt_q == '0) : pwm;
  assign lo = en ? (!pwm && pwm == last_q && cnt_q == '0) : !pwm;
endmodule

// file: src/tccp_timer.sv
/*
  Timer/counter with capture, compare and PWM channels, Wishbone slave.
  Assumes a classic Wishbone master on CORE_CLK; inputs synchronous.
*/
// Contract
// - Counter core is sixteen bits wide.
// - Up to four channels, all compared against the shared counter.
// - Each channel is set to capture, compare or PWM mode.
// - Capture copies the counter into the channel buffer on input event.
// - Compare drives output from counter versus programmed threshold.
// - PWM waveform follows successive values written to compare registers.
// - Dead-time insertion only in the first timer unit.
// - Count events and emit timing events onto the reflex network.
`include "tccp_defs.svh"
module tccp_timer
  import tccp_pkg::*;
#(
  parameter int  CW     = 16,
  parameter int  NCH    = 4,
  parameter bit  HAS_DT = 1'b1,
  parameter int  DW     = 8
) (
  input  wire logic           CORE_CLK,        // Core clock, 40 MHz
  input  wire logic           SYS_RST,         // Sync reset, active high
  input  wire logic           WB_CYC_I,        // Bus cycle
  input  wire logic           WB_STB_I,        // Bus strobe
  input  wire logic           WB_WE_I,         // Write enable
  input  wire logic [7:0]     WB_ADR_I,        // Byte address
  input  wire logic [3:0]     WB_SEL_I,        // Byte lanes
  input  wire logic [31:0]    WB_DAT_I,        // Write data
  output logic [31:0]         WB_DAT_O,        // Read data
  output logic                WB_ACK_O,        // Acknowledge
  input  wire logic           EXT_TICK,        // External count event
  input  wire logic [NCH-1:0] CAP_IN,          // Capture inputs
  output logic [NCH-1:0]      CH_OUT,          // Channel outputs
  output logic [NCH-1:0]      CH_OUT_N,        // Complementary outputs
  output logic [NCH-1:0]      REFLEX_SIGNAL_NETWORK_CH, // Channel events
  output logic                REFLEX_SIGNAL_NETWORK_OVF // Overflow event
);
  logic                    run_q, extclk_q, dten_q;
  logic [CW-1:0]           top_q;
  logic [CW-1:0]           cnt_q;
  logic [DW-1:0]           dtime_q;
  logic [NCH-1:0]          flag_q;
  logic                    ovf_q;
  logic [1:0]              mode_q  [NCH];
  logic [1:0]              edge_q  [NCH];
  logic [NCH-1:0]          inv_q;
  logic [CW-1:0]           ch_val  [NCH];
  logic [NCH-1:0]          ch_hit, ch_out, dt_hi, dt_lo, val_we;
  logic                    tick, wrap, wr, rd;
  logic                    ext_prev_q;
  logic [31:0]             rdata;
  logic [31:0]             wmask;

  // Byte-lane mask from SEL
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Channel index of an address inside a per-channel window, or NCH
  function automatic int ch_index(input logic [7:0] adr, input logic [7:0] base);
    int idx;
    idx = NCH;
    for (int i = 0; i < NCH; i++)
      if (adr == base + 8'(i * 4)) idx = i;
    return idx;
  endfunction

  assign wr    = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
  assign rd    = WB_CYC_I && WB_STB_I && !WB_WE_I && !WB_ACK_O;
  assign wmask = lane_mask(WB_SEL_I);

  // Count tick: free running or rising edge of the external event
  assign tick = run_q && (extclk_q ? (EXT_TICK && !ext_prev_q) : 1'b1);
  assign wrap = tick && (cnt_q == top_q);

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) ext_prev_q <= 1'b0;
    else ext_prev_q <= EXT_TICK;
  end

  // Counter; a software write to the count wins over a tick
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) cnt_q <= '0;
    else if (wr && WB_ADR_I == `TCCP_OFF_CNT)
      cnt_q <= (cnt_q & ~wmask[CW-1:0]) | (WB_DAT_I[CW-1:0] & wmask[CW-1:0]);
    else if (wrap) cnt_q <= '0;
    else if (tick) cnt_q <= cnt_q + 1'b1;
  end

  // Control, top and dead-time registers
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      run_q    <= 1'b0;
      extclk_q <= 1'b0;
      dten_q   <= 1'b0;
      top_q    <= `TCCP_RST_TOP;
      dtime_q  <= `TCCP_RST_DTIME;
    end else if (wr) begin
      if (WB_ADR_I == `TCCP_OFF_CTRL && WB_SEL_I[0]) begin
        run_q    <= WB_DAT_I[`TCCP_CTRL_RUN];
        extclk_q <= WB_DAT_I[`TCCP_CTRL_EXTCLK];
        dten_q   <= HAS_DT && WB_DAT_I[`TCCP_CTRL_DTEN];
      end
      if (WB_ADR_I == `TCCP_OFF_TOP)
        top_q <= (top_q & ~wmask[CW-1:0]) | (WB_DAT_I[CW-1:0] & wmask[CW-1:0]);
      if (WB_ADR_I == `TCCP_OFF_DTIME && WB_SEL_I[0])
        dtime_q <= WB_DAT_I[DW-1:0];
    end
  end

  // Per-channel configuration
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NCH; i++) begin
        mode_q[i] <= TCCP_MODE_OFF;
        edge_q[i] <= TCCP_EDGE_RISE;
      end
      inv_q <= '0;
    end else if (wr && WB_SEL_I[0] && ch_index(WB_ADR_I, `TCCP_OFF_CHCFG0) < NCH) begin
      mode_q[ch_index(WB_ADR_I, `TCCP_OFF_CHCFG0)] <= WB_DAT_I[`TCCP_CFG_MODE_LO +: 2];
      edge_q[ch_index(WB_ADR_I, `TCCP_OFF_CHCFG0)] <= WB_DAT_I[`TCCP_CFG_EDGE_LO +: 2];
      inv_q[ch_index(WB_ADR_I, `TCCP_OFF_CHCFG0)]  <= WB_DAT_I[`TCCP_CFG_INV];
    end
  end

  // Threshold write strobes; whole-word write only for simplicity
  always_comb begin
    val_we = '0;
    for (int i = 0; i < NCH; i++)
      val_we[i] = wr && (WB_ADR_I == `TCCP_OFF_CHVAL0 + 8'(i * 4));
  end

  // Sticky flags: hardware set wins over a clear in the same cycle
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      flag_q <= '0;
      ovf_q  <= 1'b0;
    end else begin
      if (wr && WB_ADR_I == `TCCP_OFF_CLEAR && WB_SEL_I[0]) begin
        flag_q <= (flag_q & ~WB_DAT_I[NCH-1:0]) | ch_hit;
        ovf_q  <= (ovf_q & ~WB_DAT_I[`TCCP_STAT_OVF]) | wrap;
      end else begin
        flag_q <= flag_q | ch_hit;
        ovf_q  <= ovf_q | wrap;
      end
    end
  end

  // Channels against the shared counter
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    tccp_channel #(.CW(CW)) u_ch (
      .clk      (CORE_CLK),
      .rst      (SYS_RST),
      .mode     (mode_q[g]),
      .edge_sel (edge_q[g]),
      .inv      (inv_q[g]),
      .cnt      (cnt_q),
      .tick     (tick),
      .wrap     (wrap),
      .cap_in   (CAP_IN[g]),
      .val_we   (val_we[g]),
      .val_wd   (WB_DAT_I[CW-1:0]),
      .val      (ch_val[g]),
      .hit      (ch_hit[g]),
      .out      (ch_out[g])
    );
    if (HAS_DT) begin : g_dt
      tccp_deadtime #(.DW(DW)) u_dt (
        .clk (CORE_CLK),
        .rst (SYS_RST),
        .en  (dten_q && mode_q[g] == TCCP_MODE_PWM),
        .gap (dtime_q),
        .pwm (ch_out[g]),
        .hi  (dt_hi[g]),
        .lo  (dt_lo[g])
      );
    end else begin : g_nodt
      assign dt_hi[g] = ch_out[g];
      assign dt_lo[g] = !ch_out[g];
    end
  end

  // Registered pin and reflex outputs
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      CH_OUT                    <= '0;
      CH_OUT_N                  <= '0;
      REFLEX_SIGNAL_NETWORK_CH  <= '0;
      REFLEX_SIGNAL_NETWORK_OVF <= 1'b0;
    end else begin
      CH_OUT                    <= dt_hi;
      CH_OUT_N                  <= dt_lo;
      REFLEX_SIGNAL_NETWORK_CH  <= ch_hit;
      REFLEX_SIGNAL_NETWORK_OVF <= wrap;
    end
  end

  // Read decode; unmapped reads return zero
  always_comb begin
    rdata = '0;
    unique case (WB_ADR_I)
      `TCCP_OFF_CTRL:   rdata = {29'h0, dten_q, extclk_q, run_q};
      `TCCP_OFF_TOP:    rdata = {16'h0, top_q};
      `TCCP_OFF_CNT:    rdata = {16'h0, cnt_q};
      `TCCP_OFF_STATUS: rdata = {27'h0, ovf_q, flag_q};
      `TCCP_OFF_DTIME:  rdata = {24'h0, dtime_q};
      default: begin
        for (int i = 0; i < NCH; i++) begin
          if (WB_ADR_I == `TCCP_OFF_CHCFG0 + 8'(i * 4))
            rdata = {27'h0, inv_q[i], edge_q[i], mode_q[i]};
          if (WB_ADR_I == `TCCP_OFF_CHVAL0 + 8'(i * 4))
            rdata = {16'h0, ch_val[i]};
        end
      end
    endcase
  end

  // One-cycle ack per request; released cycle before next request
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= wr || rd;
      if (rd) WB_DAT_O <= rdata;
    end
  end
endmodule

// file: test/tccp_timer_props.sv
/* Port checker for the timer block: bus handshake, reset, output pairs.
   Assumes it is bound to tccp_timer; one clock, synchronous reset. */
module tccp_timer_props #(
  parameter int NCH = 4
) (
  input wire logic           CORE_CLK,                 // Clock
  input wire logic           SYS_RST,                  // Reset
  input wire logic           WB_CYC_I,                 // Cycle
  input wire logic           WB_STB_I,                 // Strobe
  input wire logic           WB_WE_I,                  // Write
  input wire logic [31:0]    WB_DAT_O,                 // Read data
  input wire logic           WB_ACK_O,                 // Ack
  input wire logic [NCH-1:0] CH_OUT,                   // Outputs
  input wire logic [NCH-1:0] CH_OUT_N,                 // Complements
  input wire logic [NCH-1:0] REFLEX_SIGNAL_NETWORK_CH, // Channel events
  input wire logic           REFLEX_SIGNAL_NETWORK_OVF // Overflow event
);
  // Single domain, so one default clock and disable
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  a_ack_after_req: assert property ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held too long");
  a_ack_needs_req: assert property ($rose(WB_ACK_O) |-> $past(WB_CYC_I) && $past(WB_STB_I))
    else $error("ack without request");
  a_dat_on_read: assert property (!$stable(WB_DAT_O) |-> WB_ACK_O && !WB_WE_I)
    else $error("read data moved outside a read ack");
  a_pair_no_overlap: assert property (~|(CH_OUT & CH_OUT_N))
    else $error("both sides of a pair high");
  a_pair_after_rst: assert property ($fell(SYS_RST) |-> ##2 (CH_OUT_N == ~CH_OUT))
    else $error("complement wrong after reset");
  // Reset itself is the cause here, so this one is never disabled
  a_rst_quiet_out: assert property (disable iff (1'b0)
    SYS_RST |=> !WB_ACK_O && ~|CH_OUT && ~|CH_OUT_N)
    else $error("outputs active after reset");
  a_rst_quiet_evt: assert property (disable iff (1'b0)
    SYS_RST |=> !REFLEX_SIGNAL_NETWORK_OVF && ~|REFLEX_SIGNAL_NETWORK_CH)
    else $error("events active after reset");
endmodule

bind tccp_timer tccp_timer_props #(.NCH(NCH)) tccp_timer_props_inst (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CH_OUT(CH_OUT),
  .CH_OUT_N(CH_OUT_N), .REFLEX_SIGNAL_NETWORK_CH(REFLEX_SIGNAL_NETWORK_CH),
  .REFLEX_SIGNAL_NETWORK_OVF(REFLEX_SIGNAL_NETWORK_OVF)
);

// file: test/tccp_far_model.sv
/* Far-side model: reflex event consumer, source of count and capture events.
   Assumes the timer clock; its tasks are called just after a rising edge. */
module tccp_far_model (
  input  wire logic       clk,      // Core clock
  input  wire logic       rst,      // Sync reset
  input  wire logic       ovf,      // Overflow event
  input  wire logic [3:0] ch_evt,   // Channel events
  output logic            ext_tick, // Count event
  output logic [3:0]      cap_in,   // Capture levels
  output int              ovf_gap,  // Clocks between overflows
  output int              ch_gap    // Clocks between channel 0 events
);
  int now;
  int ovf_t;
  int ch_t;
  // Event spacing gives the period without touching registers
  always @(posedge clk) begin
    now <= rst ? 0 : now + 1;
    if (ovf) begin
      ovf_gap <= now - ovf_t;
      ovf_t   <= now;
    end
    if (ch_evt[0]) begin
      ch_gap <= now - ch_t;
      ch_t   <= now;
    end
  end
  // Levels start low
  initial begin
    ext_tick = 1'b0;
    cap_in   = 4'h0;
  end
  // One clock high, one low, so every pulse is a clean rising edge
  task automatic tick(input int n);
    repeat (n) begin
      ext_tick <= 1'b1;
      @(posedge clk);
      ext_tick <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic cap(input logic [3:0] v);
    cap_in <= v;
    @(posedge clk);
  endtask
endmodule

// file: test/tb_top.sv
/* Self-checking bench for the timer block with a far-side model.
   Assumes tccp_pkg compiled first; registers reached over Wishbone. */
module tb_top
  import tccp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst, cyc, stb, we, ack, ovf, ext_tick;
  logic [7:0]  adr;
  logic [3:0]  sel, ch_out, ch_out_n, ch_evt, cap_in;
  logic [31:0] wdat, rdat, r;
  logic [15:0] seed;
  int          ovf_gap, ch_gap, miscompares, checked, hi, tg, dl;
  logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h14, 8'h20, 8'h40, 8'h30};
  logic [31:0] rv [7] = '{32'h0, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  tccp_timer tccp_timer_inst (
    .CORE_CLK(clk), .SYS_RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .EXT_TICK(ext_tick), .CAP_IN(cap_in), .CH_OUT(ch_out), .CH_OUT_N(ch_out_n),
    .REFLEX_SIGNAL_NETWORK_CH(ch_evt), .REFLEX_SIGNAL_NETWORK_OVF(ovf));
  tccp_far_model tccp_far_inst (
    .clk(clk), .rst(rst), .ovf(ovf), .ch_evt(ch_evt), .ext_tick(ext_tick),
    .cap_in(cap_in), .ovf_gap(ovf_gap), .ch_gap(ch_gap));

  // 40 MHz core clock
  always #12.5 clk = ~clk;

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int period(input int top);
    return top + 1;
  endfunction
  // PWM is set at wrap and cleared after the match cycle, so high lasts threshold plus one
  function automatic int duty(input int thr);
    return thr + 1;
  endfunction
  // Each edge of the raw level gives gap plus the edge cycle of both sides low
  function automatic int dead_low(input int gap);
    return 2 * (gap + 1);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Classic cycle: hold until ack is sampled, then idle one clock
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      summarize();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // Eight samples span one period whatever the phase
  task automatic watch();
    logic p;
    hi = 0;
    tg = 0;
    dl = 0;
    p = ch_out[0];
    repeat (8) begin
      @(posedge clk);
      hi += int'(ch_out[1]);
      tg += int'(ch_out[0] != p);
      dl += int'(!ch_out[1] && !ch_out_n[1]);
      p = ch_out[0];
    end
  endtask

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {cyc, stb, we, adr, wdat} = '0;
    sel = 4'hf;
    seed = 16'h000c;
    miscompares = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      wb(1'b0, ra[i], 32'h0, r);
      check(r, rv[i]);
    end
    // Random values must stick; the unmapped hole must stay zero
    repeat (4) begin
      seed = lfsr(seed);
      wb(1'b1, 8'h04, {16'h0, seed}, r);
      wb(1'b1, 8'h30, {seed, seed}, r);
      wb(1'b0, 8'h04, 32'h0, r);
      check(r, {16'h0, seed});
      wb(1'b0, 8'h30, 32'h0, r);
      check(r, 32'h0);
    end
    $display("registers done");
    wb(1'b1, 8'h04, 32'h7, r);
    wb(1'b1, 8'h08, 32'h0, r);
    wb(1'b1, 8'h20, {30'h0, TCCP_MODE_COMPARE}, r);
    wb(1'b1, 8'h40, 32'h3, r);
    wb(1'b1, 8'h24, {30'h0, TCCP_MODE_PWM}, r);
    wb(1'b1, 8'h44, 32'h2, r);
    wb(1'b1, 8'h00, 32'h1, r);
    repeat (20) @(posedge clk);
    check(ovf_gap, period(7));
    check(ch_gap, period(7));
    watch();
    check(tg, 1);
    check(hi, duty(2));
    check(dl, 0);
    wb(1'b1, 8'h44, 32'h5, r);
    repeat (16) @(posedge clk);
    watch();
    check(hi, duty(5));
    // Gap of one keeps both phases at least as long as the dead time
    wb(1'b1, 8'h14, 32'h1, r);
    wb(1'b1, 8'h00, 32'h5, r);
    repeat (16) @(posedge clk);
    watch();
    check(dl, dead_low(1));
    wb(1'b1, 8'h00, 32'h0, r);
    wb(1'b0, 8'h0c, 32'h0, r);
    check(r & 32'h13, 32'h13);
    wb(1'b1, 8'h10, 32'h1f, r);
    wb(1'b0, 8'h0c, 32'h0, r);
    check(r, 32'h0);
    $display("waveforms done");
    seed = lfsr(seed);
    wb(1'b1, 8'h08, {16'h0, seed}, r);
    wb(1'b1, 8'h28, {30'h0, TCCP_MODE_CAPTURE}, r);
    tccp_far_inst.cap(4'h4);
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h48, 32'h0, r);
    check(r, {16'h0, seed});
    wb(1'b0, 8'h0c, 32'h0, r);
    check(r & 32'h4, 32'h4);
    // Falling-edge capture on the same channel, then a forced-high output by inversion
    seed = lfsr(seed);
    wb(1'b1, 8'h08, {16'h0, seed}, r);
    wb(1'b1, 8'h28, 32'h5, r);
    tccp_far_inst.cap(4'h0);
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h48, 32'h0, r);
    check(r, {16'h0, seed});
    wb(1'b1, 8'h2c, 32'h10, r);
    repeat (3) @(posedge clk);
    check({31'h0, ch_out[3]}, 32'h1);
    $display("capture done");
    wb(1'b1, 8'h08, 32'h0, r);
    wb(1'b1, 8'h00, 32'h3, r);
    tccp_far_inst.tick(5);
    repeat (3) @(posedge clk);
    wb(1'b0, 8'h08, 32'h0, r);
    check(r, 32'h5);
    $display("event count done");
    summarize();
  end
endmodule
